// File: design/door_contactor_map.vh
// register offsets, fields, reset values and timing counts for the sequencer
`ifndef DOOR_CONTACTOR_MAP_VH
`define DOOR_CONTACTOR_MAP_VH
`define CLK_FREQ_HZ          100000000
`define MS_TICK_CYCLES       (`CLK_FREQ_HZ / 1000)
`define OFS_CONTROL          8'h00
`define OFS_DOOR_THRESHOLD   8'h04
`define OFS_BRAKE_CLOSE      8'h08
`define OFS_RELEASE_DELAY    8'h0c
`define OFS_SPEED            8'h10
`define OFS_STATUS           8'h14
`define OFS_CONT_DELAY       8'h18
`define OFS_TRIP_CTRL        8'h1c
`define CTL_DOOR_SRC_LSB     0
`define CTL_DOOR_FLIP        8
`define CTL_DOUT_SRC_LSB     9
`define CTL_RELAY_SRC_LSB    17
`define CTL_MON_EN           25
`define CTL_FAST_DIS_EN      26
`define CTL_RESET            32'h0000_0000
`define SRC_DOOR_FLAG        8'h01
`define SRC_CONTACTOR        8'h02
`define ST_DOOR_FLAG         0
`define ST_CONTACTOR         1
`define ST_CONT_TRIP         2
`define ST_OC_TRIP           3
`define ST_POWER_STAGE       4
`define ST_OC_LOCKED         5
`define TRIP_CLR_CONT        0
`define TRIP_CLR_OC          1
`define STO_DEBOUNCE_MS      100
`define FEEDBACK_LIMIT_MS    2000
`define OC_LOCK_MS           10000
`define FAST_DISABLE_NS      650
`define FAST_DISABLE_CYCLES  ((`FAST_DISABLE_NS * 100) / 1000)
`define DEFAULT_THRESH_MMS   16'h0064
`define DEFAULT_BRAKE_MS     16'h00c8
`endif

// File: design/door_contactor_sequencer.v
// lift drive door-opening and motor contactor sequencer with ahb-lite registers
// Behaviour
// RULE_01: door flag from comparing car speed with programmed threshold, sent to output
// RULE_02: software-writable door threshold register in mm/s
// RULE_03: door terminal driven only when its source select equals door flag code
// RULE_04: polarity flip bit inverts door terminal
// RULE_05: status bit reads internal door flag
// RULE_06: contactor drive routed to digital output or relay by source selects
// RULE_07: contactor output never changes while drive enable active
// RULE_08: power stage held off 100 ms after safe-torque-off enable goes active
// RULE_09: contactor opening delayed by brake closing time at end of travel
// RULE_10: signed ms contactor delay reported; negative means opening during enable; code reports brake plus release delay minus the ms enable was on
// RULE_11: controller keeps reported delay positive, ideally 50 to 100 ms
// RULE_12: monitor enable bit gates contactor feedback supervision
// RULE_13: fault trip if feedback closed 2 s after reaching floor level
// RULE_14: separate programmable contactor release delay
// RULE_15: controller removes safe-torque-off enable within 4 ms of opening safety
// RULE_16: no torque whenever safe-torque-off enable is open
// RULE_17: fast-disable input inactive turns power stage off within 650 ns
// RULE_18: overcurrent trip reset refused for 10 s
// RULE_19: door flag only while travelling below threshold, clear when not travelling
// RULE_20: all delays count a common 1 ms tick, counters cleared on reset; the fast-disable timeout counts clock cycles instead
`include "door_contactor_map.vh"
module door_contactor_sequencer #(
   parameter STO_DEBOUNCE_MS   = `STO_DEBOUNCE_MS,
   parameter FEEDBACK_LIMIT_MS = `FEEDBACK_LIMIT_MS,
   parameter OC_LOCK_MS        = `OC_LOCK_MS,
   parameter MS_TICK_CYCLES    = `MS_TICK_CYCLES
) (
   input  wire        clock_in,
   input  wire        srst_in,
   input  wire        hsel_in,
   input  wire [31:0] haddr_in,
   input  wire [1:0]  htrans_in,
   input  wire        hwrite_in,
   input  wire [2:0]  hsize_in,
   input  wire [31:0] hwdata_in,
   input  wire        hready_in,
   output wire        hreadyout_out,
   output wire        hresp_out,
   output reg  [31:0] hrdata_out,
   input  wire        drive_enable_in,
   input  wire        sto_enable_in,
   input  wire        fast_disable_input_in,
   input  wire        travel_in,
   input  wire        at_floor_in,
   input  wire        contactor_feedback_input_in,
   input  wire        overcurrent_in,
   output reg         door_terminal_out,
   output reg         digital_output_out,
   output reg         relay_output_out,
   output reg         power_stage_enable_out,
   output reg         contactor_fault_trip_out,
   output reg         output_overcurrent_trip_out
);
   reg  [31:0] control;
   reg  [15:0] door_open_speed_threshold;
   reg  [15:0] brake_closing_time;
   reg  [15:0] contactor_release_delay;
   reg  [15:0] car_speed;
   reg         door_open_flag;
   reg         contactor_drive_output;
   reg  [15:0] contactor_delay_time;
   reg  [15:0] enable_off_ms;
   reg         enable_prev;
   reg  [31:0] tick_count;
   reg         ms_tick;
   reg  [15:0] sto_ms;
   reg  [15:0] floor_ms;
   reg  [15:0] oc_ms;
   reg  [15:0] open_wait_ms;
   reg         open_pending;
   reg  [7:0]  fast_cnt;
   reg         fast_kill;
   reg         ph_valid;
   reg         ph_write;
   reg  [7:0]  ph_addr;
   reg  [31:0] next_rdata;
   reg         rd_late;
   wire [7:0]  door_src  = control[`CTL_DOOR_SRC_LSB+7:`CTL_DOOR_SRC_LSB];
   wire [7:0]  dout_src  = control[`CTL_DOUT_SRC_LSB+7:`CTL_DOUT_SRC_LSB];
   wire [7:0]  relay_src = control[`CTL_RELAY_SRC_LSB+7:`CTL_RELAY_SRC_LSB];
   wire        mon_en    = control[`CTL_MON_EN];
   wire        fast_en   = control[`CTL_FAST_DIS_EN];
   wire [15:0] speed_mag = car_speed[15] ? (~car_speed + 16'h0001) : car_speed;
   wire        wr_en     = ph_valid & ph_write;
   wire        rd_req    = hready_in & hsel_in & htrans_in[1] & ~hwrite_in;
   wire [7:0]  rd_addr   = rd_late ? ph_addr : haddr_in[7:0];
   wire        oc_locked = output_overcurrent_trip_out & (oc_ms < OC_LOCK_MS);
   wire        sto_ok    = sto_enable_in & (sto_ms >= STO_DEBOUNCE_MS);
   wire        fast_ok   = ~fast_en | ~fast_kill;
   wire [15:0] open_target = brake_closing_time + contactor_release_delay;

   assign hreadyout_out = ~rd_late;
   assign hresp_out     = 1'b0;

   // ahb-lite address phase capture
   always @(posedge clock_in) begin
      if (srst_in) begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_addr  <= 8'h00;
      end else if (hready_in) begin
         ph_valid <= hsel_in & htrans_in[1];
         ph_write <= hwrite_in;
         ph_addr  <= haddr_in[7:0];
      end
   end

   // register writes
   always @(posedge clock_in) begin
      if (srst_in) begin
         control                   <= `CTL_RESET;
         door_open_speed_threshold <= `DEFAULT_THRESH_MMS;
         brake_closing_time        <= `DEFAULT_BRAKE_MS;
         contactor_release_delay   <= 16'h0000;
         car_speed                 <= 16'h0000;
      end else if (wr_en) begin
         if (ph_addr == `OFS_CONTROL) begin
            control <= hwdata_in;
         end else if (ph_addr == `OFS_DOOR_THRESHOLD) begin
            door_open_speed_threshold <= hwdata_in[15:0]; // see RULE_02
         end else if (ph_addr == `OFS_BRAKE_CLOSE) begin
            brake_closing_time <= hwdata_in[15:0];
         end else if (ph_addr == `OFS_RELEASE_DELAY) begin
            contactor_release_delay <= hwdata_in[15:0]; // see RULE_14
         end else if (ph_addr == `OFS_SPEED) begin
            car_speed <= hwdata_in[15:0];
         end
      end
   end

   // read mux on the address phase, or on a read held behind a write
   always @* begin
      next_rdata = 32'h0000_0000;
      if (rd_addr == `OFS_CONTROL) begin
         next_rdata = control;
      end else if (rd_addr == `OFS_DOOR_THRESHOLD) begin
         next_rdata = {16'h0000, door_open_speed_threshold};
      end else if (rd_addr == `OFS_BRAKE_CLOSE) begin
         next_rdata = {16'h0000, brake_closing_time};
      end else if (rd_addr == `OFS_RELEASE_DELAY) begin
         next_rdata = {16'h0000, contactor_release_delay};
      end else if (rd_addr == `OFS_SPEED) begin
         next_rdata = {16'h0000, car_speed};
      end else if (rd_addr == `OFS_STATUS) begin
         next_rdata[`ST_DOOR_FLAG]   = door_open_flag; // see RULE_05
         next_rdata[`ST_CONTACTOR]   = contactor_drive_output;
         next_rdata[`ST_CONT_TRIP]   = contactor_fault_trip_out;
         next_rdata[`ST_OC_TRIP]     = output_overcurrent_trip_out;
         next_rdata[`ST_POWER_STAGE] = power_stage_enable_out;
         next_rdata[`ST_OC_LOCKED]   = oc_locked;
      end else if (rd_addr == `OFS_CONT_DELAY) begin
         next_rdata = {{16{contactor_delay_time[15]}}, contactor_delay_time}; // see RULE_10
      end
   end

   // read data loaded at the address phase edge, stands through the data phase
   // a read meeting a write data phase waits one cycle for the written value
   always @(posedge clock_in) begin
      if (srst_in) begin
         rd_late    <= 1'b0;
         hrdata_out <= 32'h0000_0000;
      end else begin
         rd_late <= rd_req & wr_en;
         if ((rd_req && !wr_en) || rd_late) begin
            hrdata_out <= next_rdata; // see RULE_05
         end
      end
   end

   // 1 ms time base
   always @(posedge clock_in) begin
      if (srst_in) begin
         tick_count <= 32'h0000_0000;
         ms_tick    <= 1'b0;
      end else if (tick_count == MS_TICK_CYCLES - 1) begin
         tick_count <= 32'h0000_0000; // see RULE_20
         ms_tick    <= 1'b1;
      end else begin
         tick_count <= tick_count + 32'h0000_0001;
         ms_tick    <= 1'b0;
      end
   end

   // door opening flag and terminal
   always @(posedge clock_in) begin
      if (srst_in) begin
         door_open_flag    <= 1'b0;
         door_terminal_out <= 1'b0;
      end else begin
         door_open_flag <= travel_in & (speed_mag < door_open_speed_threshold); // see RULE_01 RULE_19
         if (door_src == `SRC_DOOR_FLAG) begin
            door_terminal_out <= door_open_flag ^ control[`CTL_DOOR_FLIP]; // see RULE_03 RULE_04
         end else begin
            door_terminal_out <= 1'b0;
         end
      end
   end

   // safe-torque-off debounce, fast disable and power stage
   always @(posedge clock_in) begin
      if (srst_in) begin
         sto_ms    <= 16'h0000;
         fast_cnt  <= 8'h00;
         fast_kill <= 1'b0;
         power_stage_enable_out <= 1'b0;
      end else begin
         if (!sto_enable_in) begin
            sto_ms <= 16'h0000;
         end else if (ms_tick && sto_ms < STO_DEBOUNCE_MS) begin
            sto_ms <= sto_ms + 16'h0001; // see RULE_08
         end
         if (fast_disable_input_in) begin
            fast_cnt  <= 8'h00;
            fast_kill <= 1'b0;
         end else if (fast_cnt < `FAST_DISABLE_CYCLES - 2) begin
            fast_cnt <= fast_cnt + 8'h01;
         end else begin
            fast_kill <= 1'b1; // see RULE_17
         end
         power_stage_enable_out <= sto_ok & drive_enable_in & fast_ok & sto_enable_in
                                   & ~output_overcurrent_trip_out; // see RULE_16
      end
   end

   // contactor drive, opening delay and delay report
   always @(posedge clock_in) begin
      if (srst_in) begin
         contactor_drive_output <= 1'b0;
         open_pending           <= 1'b0;
         open_wait_ms           <= 16'h0000;
         enable_off_ms          <= 16'h0000;
         enable_prev            <= 1'b0;
         contactor_delay_time   <= 16'h0000;
      end else begin
         enable_prev <= drive_enable_in;
         if (drive_enable_in) begin
            open_pending <= 1'b0; // see RULE_07
            open_wait_ms <= 16'h0000;
            if (!enable_prev) begin
               enable_off_ms <= 16'h0000;
            end else if (ms_tick) begin
               enable_off_ms <= enable_off_ms + 16'h0001;
            end
         end else if (!contactor_drive_output && travel_in) begin
            contactor_drive_output <= 1'b1;
         end else if (contactor_drive_output && !travel_in && !open_pending) begin
            open_pending <= 1'b1;
            open_wait_ms <= 16'h0000;
         end else if (open_pending) begin
            if (open_wait_ms >= open_target) begin
               contactor_drive_output <= 1'b0; // see RULE_09
               open_pending           <= 1'b0;
            end else if (ms_tick) begin
               open_wait_ms <= open_wait_ms + 16'h0001;
            end
         end
         if (enable_prev && !drive_enable_in) begin
            contactor_delay_time <= open_target - enable_off_ms; // see RULE_10
         end
      end
   end

   always @(posedge clock_in) begin
      if (srst_in) begin
         digital_output_out <= 1'b0;
         relay_output_out   <= 1'b0;
      end else begin
         digital_output_out <= (dout_src == `SRC_CONTACTOR) ? contactor_drive_output
                             : (dout_src == `SRC_DOOR_FLAG) ? door_open_flag : 1'b0; // see RULE_06
         relay_output_out   <= (relay_src == `SRC_CONTACTOR) & contactor_drive_output;
      end
   end

   // contactor feedback supervision and overcurrent lockout
   always @(posedge clock_in) begin
      if (srst_in) begin
         floor_ms                    <= 16'h0000;
         oc_ms                       <= 16'h0000;
         contactor_fault_trip_out    <= 1'b0;
         output_overcurrent_trip_out <= 1'b0;
      end else begin
         if (!mon_en || !at_floor_in || !contactor_feedback_input_in) begin
            floor_ms <= 16'h0000; // see RULE_12
         end else if (floor_ms >= FEEDBACK_LIMIT_MS) begin
            contactor_fault_trip_out <= 1'b1; // see RULE_13
         end else if (ms_tick) begin
            floor_ms <= floor_ms + 16'h0001;
         end
         if (wr_en && ph_addr == `OFS_TRIP_CTRL && hwdata_in[`TRIP_CLR_CONT]
             && !(mon_en && floor_ms >= FEEDBACK_LIMIT_MS)) begin
            contactor_fault_trip_out <= 1'b0;
         end
         if (overcurrent_in) begin
            output_overcurrent_trip_out <= 1'b1;
            oc_ms                       <= 16'h0000;
         end else if (wr_en && ph_addr == `OFS_TRIP_CTRL && hwdata_in[`TRIP_CLR_OC]
                      && !oc_locked) begin
            output_overcurrent_trip_out <= 1'b0; // see RULE_18
         end else if (ms_tick && oc_locked) begin
            oc_ms <= oc_ms + 16'h0001;
         end
      end
   end
endmodule // door_contactor_sequencer

// File: verif/lift_controller_model.sv
// lift controller model driving the enable and safety lines
module lift_controller_model (
   input  wire  clock_in,
   input  wire  srst_in,
   input  wire  run_in,
   input  wire  stuck_in,
   input  wire  contactor_in,
   output logic drive_enable_out,
   output logic sto_enable_out,
   output logic travel_out,
   output logic at_floor_out,
   output logic feedback_out
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(posedge clock_in) begin
      if (srst_in) begin
         {drive_enable_out, sto_enable_out, travel_out, at_floor_out, feedback_out} <= 5'h00;
      end else begin
         travel_out <= run_in;
         at_floor_out <= !run_in;
         // aux contact follows contactor, may stick
         feedback_out <= stuck_in | contactor_in;
         // enable and safety drop together on stop
         drive_enable_out <= run_in & feedback_out;
         sto_enable_out <= run_in & feedback_out;
      end
   end
endmodule // lift_controller_model

// File: verif/door_contactor_sequencer_asserts.sv
// port checker for the door and contactor sequencer
module door_contactor_sequencer_asserts #(
   parameter STO_DEBOUNCE_MS = 4, FEEDBACK_LIMIT_MS = 8, OC_LOCK_MS = 10, MS_TICK_CYCLES = 10
) (
   input wire        clock_in,
   input wire        srst_in,
   input wire        hsel_in,
   input wire [31:0] haddr_in,
   input wire [1:0]  htrans_in,
   input wire        hwrite_in,
   input wire [31:0] hwdata_in,
   input wire        hready_in,
   input wire        drive_enable_in,
   input wire        sto_enable_in,
   input wire        fast_disable_input_in,
   input wire        travel_in,
   input wire        at_floor_in,
   input wire        contactor_feedback_input_in,
   input wire        door_terminal_out,
   input wire        relay_output_out,
   input wire        power_stage_enable_out,
   input wire        contactor_fault_trip_out,
   input wire        output_overcurrent_trip_out
);
   localparam int T = MS_TICK_CYCLES;
   localparam int FAST = 65;
   logic [31:0] ctl;
   logic        wp;
   int          sc, fc, oc;
   default clocking @(posedge clock_in); endclocking
   default disable iff (srst_in);
   // shadow of control word, cycle counters
   always @(posedge clock_in) begin
      if (srst_in) begin
         ctl <= 32'h0;
         wp <= 1'b0;
         sc <= 0;
         fc <= 0;
         oc <= 0;
      end else begin
         wp <= hsel_in && htrans_in[1] && hready_in && hwrite_in && haddr_in[7:0] == 8'h00;
         if (wp) ctl <= hwdata_in;
         sc <= sto_enable_in ? sc + 1 : 0;
         fc <= (at_floor_in && contactor_feedback_input_in) ? fc + 1 : 0;
         oc <= output_overcurrent_trip_out ? oc + 1 : 0;
      end
   end
   property p_relay_hold;
      drive_enable_in && $past(drive_enable_in) |-> $stable(relay_output_out);
   endproperty
   a_relay_hold: assert property (p_relay_hold) else $error("contactor moved with enable on");
   property p_sto_off;
      !sto_enable_in ##1 !sto_enable_in |-> !power_stage_enable_out;
   endproperty
   a_sto_off: assert property (p_sto_off) else $error("power stage on without sto");
   property p_debounce;
      power_stage_enable_out |-> sc >= (STO_DEBOUNCE_MS - 1) * T;
   endproperty
   a_debounce: assert property (p_debounce) else $error("power stage on too early");
   property p_fast;
      ctl[26] && $fell(fast_disable_input_in) |-> ##[1:FAST] !power_stage_enable_out;
   endproperty
   a_fast: assert property (p_fast) else $error("fast disable too slow");
   property p_trip_early;
      $rose(contactor_fault_trip_out) |-> fc >= (FEEDBACK_LIMIT_MS - 1) * T;
   endproperty
   a_trip_early: assert property (p_trip_early) else $error("contactor trip too early");
   property p_trip_late;
      ctl[25] && fc == (FEEDBACK_LIMIT_MS + 1) * T + 3 |-> contactor_fault_trip_out;
   endproperty
   a_trip_late: assert property (p_trip_late) else $error("contactor trip missing");
   property p_no_mon;
      !ctl[25] && !$past(ctl[25]) |-> !$rose(contactor_fault_trip_out);
   endproperty
   a_no_mon: assert property (p_no_mon) else $error("trip with monitor off");
   property p_oc_lock;
      $fell(output_overcurrent_trip_out) |-> oc >= (OC_LOCK_MS - 1) * T;
   endproperty
   a_oc_lock: assert property (p_oc_lock) else $error("overcurrent cleared early");
   property p_door_off;
      ctl[7:0] != 8'h01 && $past(ctl[7:0]) != 8'h01 |-> !door_terminal_out;
   endproperty
   a_door_off: assert property (p_door_off) else $error("door terminal not routed");
   property p_relay_src;
      ctl[24:17] != 8'h02 && $past(ctl[24:17]) != 8'h02 |-> !relay_output_out;
   endproperty
   a_relay_src: assert property (p_relay_src) else $error("relay not routed");
   property p_door_idle;
      ctl[7:0] == 8'h01 && $stable(ctl) && !travel_in && !$past(travel_in)
         && !$past(travel_in, 2) |-> door_terminal_out == ctl[8];
   endproperty
   a_door_idle: assert property (p_door_idle) else $error("door flag set at rest");
   c_trip: cover property ($rose(contactor_fault_trip_out));
   c_fast: cover property (ctl[26] && $fell(fast_disable_input_in));
   c_oc: cover property ($fell(output_overcurrent_trip_out));
endmodule // door_contactor_sequencer_asserts
bind door_contactor_sequencer door_contactor_sequencer_asserts #(
   .STO_DEBOUNCE_MS(STO_DEBOUNCE_MS), .FEEDBACK_LIMIT_MS(FEEDBACK_LIMIT_MS),
   .OC_LOCK_MS(OC_LOCK_MS), .MS_TICK_CYCLES(MS_TICK_CYCLES)
) chk (.clock_in, .srst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hwdata_in,
   .hready_in, .drive_enable_in, .sto_enable_in, .fast_disable_input_in, .travel_in,
   .at_floor_in, .contactor_feedback_input_in, .door_terminal_out, .relay_output_out,
   .power_stage_enable_out, .contactor_fault_trip_out, .output_overcurrent_trip_out);

// File: verif/test_door_contactor_sequencer.sv
// testbench for the door and contactor sequencer
module test_door_contactor_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int ST = 4, FL = 40, OL = 10, T = 10;
   logic        clock_in = 1'b0, srst_in = 1'b1, hwrite = 1'b0, fdis = 1'b1, oc_in = 1'b0;
   logic        run = 1'b0, stuck = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
   wire  [31:0] hrdata;
   wire         hready, hresp, de, sto, trv, flr, fb, door, dout, relay, pse, ctrip, otrip;
   int          err_count = 0, checks = 0, n;
   always #5 clock_in = ~clock_in;
   door_contactor_sequencer #(.STO_DEBOUNCE_MS(ST), .FEEDBACK_LIMIT_MS(FL), .OC_LOCK_MS(OL),
      .MS_TICK_CYCLES(T)) uut (.clock_in(clock_in), .srst_in(srst_in), .hsel_in(1'b1),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
      .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp),
      .hrdata_out(hrdata), .drive_enable_in(de), .sto_enable_in(sto),
      .fast_disable_input_in(fdis), .travel_in(trv), .at_floor_in(flr),
      .contactor_feedback_input_in(fb), .overcurrent_in(oc_in), .door_terminal_out(door),
      .digital_output_out(dout), .relay_output_out(relay), .power_stage_enable_out(pse),
      .contactor_fault_trip_out(ctrip), .output_overcurrent_trip_out(otrip));
   lift_controller_model ctl_model (.clock_in(clock_in), .srst_in(srst_in), .run_in(run),
      .stuck_in(stuck), .contactor_in(relay), .drive_enable_out(de), .sto_enable_out(sto),
      .travel_out(trv), .at_floor_out(flr), .feedback_out(fb));
   task end_sim;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task rng(input int v, input int lo, input int hi);
      checks++;
      if (v < lo || v > hi) begin
         err_count++;
         $display("unexpected at %0t: count %0d outside %0d..%0d", $time, v, lo, hi);
      end
   endtask
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clock_in); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock_in); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task cyc(input int c);
      repeat (c) @(posedge clock_in);
   endtask
   task go;
      run <= 1'b1;
      for (n = 0; n < 500 && sto !== 1'b1; n++) @(posedge clock_in);
      for (n = 0; n < 500 && pse !== 1'b1; n++) @(posedge clock_in);
      rng(n, (ST - 1) * T, (ST + 1) * T + 5);
   endtask
   task stop(input int ms);
      run <= 1'b0;
      for (n = 0; n < 2000 && relay === 1'b1; n++) @(posedge clock_in);
      rng(n, (ms - 1) * T, (ms + 1) * T + 5);
      chk(pse, 1'b0);
   endtask
   initial begin
      #300000;
      err_count++;
      end_sim;
   end
   initial begin
      cyc(20);
      srst_in <= 1'b0;
      bus(0, 32'h14, 32'h0);
      chk(q, 32'h0);
      bus(1, 32'h04, 32'h64);
      bus(0, 32'h04, 32'h0);
      chk(q, 32'h64);
      bus(1, 32'h08, 32'h3);
      bus(1, 32'h0c, 32'h1);
      bus(0, 32'h0c, 32'h0);
      chk(q, 32'h1);
      bus(0, 32'h40, 32'h0);
      chk(q, 32'h0);
      $display("test registers done");
      bus(1, 32'h00, 32'h0204_0201);
      bus(1, 32'h10, 32'd50);
      go;
      cyc(3);
      chk(door, 1'b1);
      chk(dout, 1'b1);
      bus(0, 32'h14, 32'h0);
      chk(q[0], 1'b1);
      chk(hresp, 1'b0);
      bus(1, 32'h00, 32'h0204_0301);
      cyc(3);
      chk(door, 1'b0);
      bus(1, 32'h10, 32'd200);
      cyc(3);
      chk(door, 1'b1);
      bus(1, 32'h00, 32'h0204_0201);
      stop(4);
      bus(0, 32'h18, 32'h0);
      chk(q[31], 1'b1);
      $display("test travel done");
      bus(1, 32'h08, 32'd30);
      go;
      stuck <= 1'b1;
      stop(31);
      cyc((FL + 2) * T - 310);
      chk(ctrip, 1'b1);
      bus(0, 32'h18, 32'h0);
      chk(q[31], 1'b0);
      stuck <= 1'b0;
      cyc(3);
      bus(1, 32'h1c, 32'h1);
      cyc(2);
      chk(ctrip, 1'b0);
      bus(1, 32'h00, 32'h0004_0201);
      go;
      stuck <= 1'b1;
      stop(31);
      cyc((FL + 2) * T - 310);
      chk(ctrip, 1'b0);
      stuck <= 1'b0;
      $display("test feedback done");
      bus(1, 32'h00, 32'h0404_0201);
      go;
      fdis <= 1'b0;
      cyc(70);
      chk(pse, 1'b0);
      fdis <= 1'b1;
      stop(31);
      $display("test fast disable done");
      oc_in <= 1'b1;
      cyc(1);
      oc_in <= 1'b0;
      cyc(2);
      chk(otrip, 1'b1);
      bus(1, 32'h1c, 32'h2);
      cyc(2);
      chk(otrip, 1'b1);
      cyc(OL * T + 10);
      bus(1, 32'h1c, 32'h2);
      cyc(2);
      chk(otrip, 1'b0);
      $display("test overcurrent done");
      bus(1, 32'h00, 32'h0000_0500);
      run <= 1'b1;
      cyc(5);
      chk(dout, 1'b1);
      chk(relay, 1'b0);
      chk(door, 1'b0);
      run <= 1'b0;
      cyc(40 * T);
      chk(dout, 1'b0);
      $display("test routing done");
      end_sim;
   end
endmodule // test_door_contactor_sequencer
